// [design/sdai_pkg.sv]
// Notes on behaviour
// - The transmit lamp blinks on transitions of the outgoing data line and stays dark while that line is idle.
// - The receive lamp blinks on transitions of the incoming data line and stays dark while that line is idle.
// - After power-on reset the terminal-active output toward the peer is asserted and its lamp lights.
// - The ready lamp is lit exactly while the device can accept incoming data, dark otherwise.
// - The carrier lamp follows the carrier-detect input from the peer.
// - The clock lamp blinks while edges arrive on the peer's transmit clock.
// - Without edges on the peer's transmit clock the clock lamp stays dark.
// - Serial data moves at the rate of the peer's clock, with no rate setting of its own.
package sdai_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned SYS_CLK_HZ = 25_000_000;
    localparam int unsigned LAMP_HOLD_MS = 100;
    localparam int unsigned BLINK_HALF_MS = 25;
    localparam int unsigned LAMP_HOLD_CYC = SYS_CLK_HZ / 1000 * LAMP_HOLD_MS;
    localparam int unsigned BLINK_HALF_CYC = SYS_CLK_HZ / 1000 * BLINK_HALF_MS;
    localparam int unsigned LAMP_CNT_W = 22;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic LAMP_RST = 1'h0;
    localparam logic TERM_RST = 1'h0;

    // ****************************************
    // event channel positions
    // ****************************************
    localparam int unsigned EVT_TX = 0;
    localparam int unsigned EVT_RX = 1;
    localparam int unsigned EVT_CLK = 2;
    localparam int unsigned EVT_N = 3;

endpackage

// [design/sdai_top.sv]
`timescale 1ns/1ps

// ****************************************
// activity lamp: stretch and blink
// ****************************************
module sdai_blink
    import sdai_pkg::*;
#(
    parameter int unsigned HOLD_CYC = LAMP_HOLD_CYC,
    parameter int unsigned BLINK_CYC = BLINK_HALF_CYC
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic evt_i,
    output logic lamp_o,
    output logic busy_o
);
    localparam logic [LAMP_CNT_W-1:0] HOLD_LD = LAMP_CNT_W'(HOLD_CYC - 1);
    localparam logic [LAMP_CNT_W-1:0] BLINK_LD = LAMP_CNT_W'(BLINK_CYC - 1);
    localparam logic [LAMP_CNT_W-1:0] CNT_ONE = LAMP_CNT_W'(1);

    logic [LAMP_CNT_W-1:0] hold_reg;
    logic [LAMP_CNT_W-1:0] phase_reg;
    logic lamp_reg;

    assign busy_o = (hold_reg != '0);
    assign lamp_o = lamp_reg;

    // retrigger keeps the lamp blinking through a burst of activity
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            hold_reg <= '0;
        end else if (ce_i) begin
            if (evt_i) begin
                hold_reg <= HOLD_LD;
            end else if (busy_o) begin
                hold_reg <= hold_reg - CNT_ONE;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            lamp_reg <= LAMP_RST;
            phase_reg <= '0;
        end else if (ce_i) begin
            if (evt_i && !busy_o) begin
                lamp_reg <= 1'h1;
                phase_reg <= BLINK_LD;
            end else if (!evt_i && hold_reg == CNT_ONE) begin
                lamp_reg <= 1'h0;
            end else if (busy_o) begin
                if (phase_reg == '0) begin
                    lamp_reg <= ~lamp_reg;
                    phase_reg <= BLINK_LD;
                end else begin
                    phase_reg <= phase_reg - CNT_ONE;
                end
            end
        end
    end
endmodule // sdai_blink

// ****************************************
// serial port indicator top
// ****************************************
module sdai_top
    import sdai_pkg::*;
#(
    parameter int unsigned HOLD_CYC = LAMP_HOLD_CYC,
    parameter int unsigned BLINK_CYC = BLINK_HALF_CYC
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic lnk_clk_i,
    input wire logic tx_data_i,
    input wire logic rx_data_i,
    input wire logic carrier_i,
    input wire logic rx_ready_i,
    output logic txd_o,
    output logic rxd_o,
    output logic term_active_o,
    output logic term_lamp_o,
    output logic peer_ready_lamp_o,
    output logic carrier_lamp_o,
    output logic tx_lamp_o,
    output logic rx_lamp_o,
    output logic clk_lamp_o
);
    // ****************************************
    // link domain, clocked by the peer's clock
    // ****************************************
    logic lrst_s1_reg;
    logic lrst_reg;
    logic rx_s1_reg;
    logic rx_s2_reg;
    logic rxd_reg;
    logic txd_reg;
    logic [EVT_N-1:0] tgl_reg;

    // reset reaches the link side as a synchronised level
    always_ff @(posedge lnk_clk_i) begin
        lrst_s1_reg <= sys_rst_i;
        lrst_reg <= lrst_s1_reg;
    end

    always_ff @(posedge lnk_clk_i) begin
        rx_s1_reg <= rx_data_i;
        rx_s2_reg <= rx_s1_reg;
    end

    // no rate of its own: one bit per rising edge of the peer clock
    always_ff @(posedge lnk_clk_i) begin
        if (lrst_reg) begin
            txd_reg <= 1'h1;
            rxd_reg <= 1'h1;
        end else begin
            txd_reg <= tx_data_i;
            rxd_reg <= rx_s2_reg;
        end
    end

    // toggles carry transitions across; a stopped clock freezes them
    always_ff @(posedge lnk_clk_i) begin
        if (lrst_reg) begin
            tgl_reg <= '0;
        end else begin
            if (tx_data_i != txd_reg) begin
                tgl_reg[EVT_TX] <= ~tgl_reg[EVT_TX];
            end
            if (rx_s2_reg != rxd_reg) begin
                tgl_reg[EVT_RX] <= ~tgl_reg[EVT_RX];
            end
            tgl_reg[EVT_CLK] <= ~tgl_reg[EVT_CLK];
        end
    end

    assign txd_o = txd_reg;
    assign rxd_o = rxd_reg;

    // ****************************************
    // system domain crossing
    // ****************************************
    logic [EVT_N-1:0] tgl_s1_reg;
    logic [EVT_N-1:0] tgl_s2_reg;
    logic [EVT_N-1:0] tgl_s3_reg;
    logic [EVT_N-1:0] evt;
    logic car_s1_reg;
    logic car_s2_reg;

    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            tgl_s1_reg <= tgl_reg;
            tgl_s2_reg <= tgl_s1_reg;
            car_s1_reg <= carrier_i;
            car_s2_reg <= car_s1_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tgl_s3_reg <= '0;
        end else if (ce_i) begin
            tgl_s3_reg <= tgl_s2_reg;
        end
    end

    assign evt = tgl_s2_reg ^ tgl_s3_reg;

    // ****************************************
    // handshake lamps
    // ****************************************
    logic term_reg;
    logic term_lamp_reg;
    logic ready_lamp_reg;
    logic car_lamp_reg;

    // data-set-ready is always on from the peer, so it gates nothing
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            term_reg <= TERM_RST;
            term_lamp_reg <= LAMP_RST;
        end else if (ce_i) begin
            term_reg <= 1'h1;
            term_lamp_reg <= 1'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ready_lamp_reg <= LAMP_RST;
            car_lamp_reg <= LAMP_RST;
        end else if (ce_i) begin
            ready_lamp_reg <= rx_ready_i && term_reg;
            car_lamp_reg <= car_s2_reg;
        end
    end

    assign term_active_o = term_reg;
    assign term_lamp_o = term_lamp_reg;
    assign peer_ready_lamp_o = ready_lamp_reg;
    assign carrier_lamp_o = car_lamp_reg;

    // ****************************************
    // activity lamps
    // ****************************************
    logic [EVT_N-1:0] lamp;
    logic [EVT_N-1:0] busy;

    for (genvar g = 0; g < EVT_N; g++) begin : g_chan
        sdai_blink #(
            .HOLD_CYC(HOLD_CYC),
            .BLINK_CYC(BLINK_CYC)
        ) u_blink (
            .clk_i(clk_i),
            .sys_rst_i(sys_rst_i),
            .ce_i(ce_i),
            .evt_i(evt[g]),
            .lamp_o(lamp[g]),
            .busy_o(busy[g])
        );
    end

    assign tx_lamp_o = lamp[EVT_TX];
    assign rx_lamp_o = lamp[EVT_RX];
    assign clk_lamp_o = lamp[EVT_CLK];

    // ****************************************
    // checks
    // ****************************************
    property p_tx_wake;
        @(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && evt[EVT_TX] && !busy[EVT_TX]) |=> tx_lamp_o;
    endproperty
    a_tx_wake: assert property (p_tx_wake)
        else $error("tx lamp did not light on activity");

    property p_tx_dark;
        @(posedge clk_i) disable iff (sys_rst_i)
        !busy[EVT_TX] |-> !tx_lamp_o;
    endproperty
    a_tx_dark: assert property (p_tx_dark)
        else $error("tx lamp lit while idle");

    property p_rx_wake;
        @(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && evt[EVT_RX] && !busy[EVT_RX]) |=> rx_lamp_o;
    endproperty
    a_rx_wake: assert property (p_rx_wake)
        else $error("rx lamp did not light on activity");

    property p_rx_dark;
        @(posedge clk_i) disable iff (sys_rst_i)
        !busy[EVT_RX] |-> !rx_lamp_o;
    endproperty
    a_rx_dark: assert property (p_rx_dark)
        else $error("rx lamp lit while idle");

    property p_term_on;
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i |=> term_active_o && term_lamp_o;
    endproperty
    a_term_on: assert property (p_term_on)
        else $error("terminal active not asserted after reset");

    property p_term_pair;
        @(posedge clk_i) disable iff (sys_rst_i)
        term_active_o |-> term_lamp_o;
    endproperty
    a_term_pair: assert property (p_term_pair)
        else $error("terminal lamp differs from its output");

    property p_ready;
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i |=> peer_ready_lamp_o == $past(rx_ready_i && term_active_o);
    endproperty
    a_ready: assert property (p_ready)
        else $error("ready lamp does not follow ready state");

    property p_carrier;
        @(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && $past(ce_i) && $past(ce_i, 2))
            |=> carrier_lamp_o == $past(carrier_i, 3);
    endproperty
    a_carrier: assert property (p_carrier)
        else $error("carrier lamp does not follow carrier");

    property p_clk_wake;
        @(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && evt[EVT_CLK] && !busy[EVT_CLK]) |=> clk_lamp_o;
    endproperty
    a_clk_wake: assert property (p_clk_wake)
        else $error("clock lamp did not light on clock edges");

    property p_clk_dark;
        @(posedge clk_i) disable iff (sys_rst_i)
        !busy[EVT_CLK] |-> !clk_lamp_o;
    endproperty
    a_clk_dark: assert property (p_clk_dark)
        else $error("clock lamp lit without clock");

    property p_stretch;
        @(posedge clk_i) disable iff (sys_rst_i)
        (ce_i && evt[EVT_TX]) |=> busy[EVT_TX] [*8];
    endproperty
    a_stretch: assert property (p_stretch)
        else $error("activity pulse not stretched");

    property p_txd;
        @(posedge lnk_clk_i) disable iff (lrst_reg)
        !$past(lrst_reg) |-> txd_o == $past(tx_data_i);
    endproperty
    a_txd: assert property (p_txd)
        else $error("transmit data not timed from peer clock");

    c_tx_blink: cover property (@(posedge clk_i) $fell(tx_lamp_o));
    c_rx_blink: cover property (@(posedge clk_i) $fell(rx_lamp_o));
    c_clk_lost: cover property (@(posedge clk_i) $fell(busy[EVT_CLK]));
    c_carrier: cover property (@(posedge clk_i) $rose(carrier_lamp_o));
endmodule // sdai_top

// [verif/sdai_dce_model.sv]
`timescale 1ns/1ps

// ****************************************
// peer line model
// ****************************************
module sdai_dce_model (
    input wire logic run_i,
    input wire logic send_i,
    input wire logic bit_i,
    input wire logic car_i,
    output logic lnk_clk_o,
    output logic rxd_line_o,
    output logic carrier_o,
    output logic dsr_o
);
    // stands still while not running; offset keeps it off the system edges
    initial begin
        lnk_clk_o = 1'h0;
        #15;
        forever begin
            #32;
            if (run_i) begin
                lnk_clk_o = ~lnk_clk_o;
            end
        end
    end

    logic rx_bit_q = 1'h1;
    // idle line holds marks, so no stray transitions reach the device
    always @(negedge lnk_clk_o) begin
        rx_bit_q <= send_i ? bit_i : 1'h1;
    end
    assign rxd_line_o = rx_bit_q;

    assign carrier_o = car_i;
    assign dsr_o = 1'h1;
endmodule // sdai_dce_model

// [verif/testbench.sv]
`timescale 1ns/1ps

module testbench;
    import sdai_pkg::*;
    localparam int unsigned HOLD = 40;
    localparam int unsigned BLINK = 4;
    logic clk_i = 1'h0;
    logic sys_rst_i = 1'h1;
    logic ce_i = 1'h1;
    // idle at mark, the level txd takes in reset, so no false edge
    logic tx_data_i = 1'h1;
    logic rx_ready_i = 1'h0;
    logic run = 1'h1;
    logic send_tx = 1'h0;
    logic send_rx = 1'h0;
    logic rx_bit = 1'h0;
    logic car = 1'h0;
    logic live = 1'h0;
    logic prev;
    logic lnk_clk_i, rx_data_i, carrier_i, txd_o, rxd_o, term_active_o;
    logic term_lamp_o, peer_ready_lamp_o, carrier_lamp_o, tx_lamp_o, rx_lamp_o;
    logic clk_lamp_o;
    logic [2:0] rx_hist;
    logic [2:0] lamps;
    int seed = 32'hA552E0F3;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;

    assign lamps = {clk_lamp_o, rx_lamp_o, tx_lamp_o};
    always #20 clk_i = ~clk_i;

    sdai_dce_model u_dce (.run_i(run), .send_i(send_rx), .bit_i(rx_bit),
        .car_i(car), .lnk_clk_o(lnk_clk_i), .rxd_line_o(rx_data_i),
        .carrier_o(carrier_i), .dsr_o());

    sdai_top #(.HOLD_CYC(HOLD), .BLINK_CYC(BLINK)) u_dut (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .ce_i(ce_i), .lnk_clk_i(lnk_clk_i),
        .tx_data_i(tx_data_i), .rx_data_i(rx_data_i), .carrier_i(carrier_i),
        .rx_ready_i(rx_ready_i), .txd_o(txd_o), .rxd_o(rxd_o),
        .term_active_o(term_active_o), .term_lamp_o(term_lamp_o),
        .peer_ready_lamp_o(peer_ready_lamp_o),
        .carrier_lamp_o(carrier_lamp_o), .tx_lamp_o(tx_lamp_o),
        .rx_lamp_o(rx_lamp_o), .clk_lamp_o(clk_lamp_o));

    // ****************************************
    // helpers
    // ****************************************
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic got, input logic exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask

    function automatic logic exp_ready(input logic rdy, input logic term);
        return rdy & term;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic seen(input int idx, input logic exp, input int lim);
        int k;
        k = 0;
        while (lamps[idx] !== exp && k < lim) begin
            tick(1);
            k++;
        end
        chk(lamps[idx], exp, "lamp level not reached");
    endtask

    task automatic quiet(input int idx, input int n);
        logic hit;
        hit = 1'h0;
        repeat (n) begin
            tick(1);
            hit = hit | lamps[idx];
        end
        chk(hit, 1'h0, "lamp lit while idle");
    endtask

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 4000) begin
            bad_count++;
            report_and_stop();
        end
    end

    // txd_o repeats the bit of the previous link edge
    always @(posedge lnk_clk_i) begin
        prev = tx_data_i;
        rx_hist = {rx_hist[1:0], rx_data_i};
        #1;
        if (live) begin
            chk(txd_o, prev, "txd not one link edge late");
            chk(rxd_o, rx_hist[2], "rxd sync delay wrong");
        end
        if (send_tx) begin
            tx_data_i = 1'($random(seed));
        end
        rx_bit = 1'($random(seed));
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        tick(16);
        chk(term_active_o, 1'h0, "terminal active in reset");
        sys_rst_i = 1'h0;
        tick(2);
        chk(term_active_o, 1'h1, "terminal active missing");
        chk(term_lamp_o, 1'h1, "terminal lamp dark");
        live = 1'h1;
        seen(2, 1'h1, 12);
        seen(2, 1'h0, 2 * BLINK + 2);
        quiet(0, 20);
        quiet(1, 20);
        run = 1'h0;
        tick(HOLD + 12);
        quiet(2, 30);
        for (int i = 0; i < 2; i++) begin
            run = 1'h1;
            send_tx = (i == 0);
            send_rx = (i == 1);
            seen(i, 1'h1, 40);
            run = 1'h0;
            send_tx = 1'h0;
            send_rx = 1'h0;
            seen(2, 1'h1, 2 * BLINK + 2);
            tick(HOLD + 12);
            quiet(i, 20);
        end
        for (int i = 0; i < 20; i++) begin
            car = 1'($random(seed));
            rx_ready_i = 1'($random(seed));
            tick(i % 2 + 4);
            chk(carrier_lamp_o, car, "carrier lamp");
            chk(peer_ready_lamp_o, exp_ready(rx_ready_i, 1'h1), "ready");
        end
        // frozen enable must hold the lamp on its old level
        ce_i = 1'h0;
        car = ~car;
        tick(6);
        chk(carrier_lamp_o, ~car, "carrier lamp moved while frozen");
        ce_i = 1'h1;
        tick(5);
        chk(carrier_lamp_o, car, "carrier lamp after freeze");
        live = 1'h0;
        run = 1'h1;
        rx_ready_i = 1'h1;
        sys_rst_i = 1'h1;
        tick(16);
        chk(peer_ready_lamp_o, exp_ready(1'h1, 1'h0), "ready in reset");
        chk(term_lamp_o, 1'h0, "terminal lamp in reset");
        sys_rst_i = 1'h0;
        tick(2);
        chk(term_active_o, 1'h1, "terminal active after reset");
        tick(2);
        chk(peer_ready_lamp_o, exp_ready(1'h1, 1'h1), "ready after reset");
        report_and_stop();
    end
endmodule // testbench
